// [include/acc_params.svh]
// offsets, field positions, reset values and timing of the converter control
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// register byte offsets on the avalon slave
`define ACC_OFS_MODE 5'h00
`define ACC_OFS_CHAN 5'h04
`define ACC_OFS_RESULT 5'h08
`define ACC_OFS_STATUS 5'h0C
`define ACC_OFS_MASK 5'h10
`define ACC_OFS_PORT 5'h14

// field positions
`define ACC_MODE_RUN_BIT 7
`define ACC_STATUS_DONE_BIT 0
`define ACC_MASK_DONE_BIT 0

// reset values
`define ACC_RST_RUN 1'h0
`define ACC_RST_CHAN 3'h0
`define ACC_RST_RESULT 10'h000
`define ACC_RST_MASK 1'h0

// timing: clock period, sampling window and one bit-decision step
`define ACC_CLK_NS 10
`define ACC_CONV_NS 720
`define ACC_SAMPLE_NS 120
`define ACC_STEP_NS 60
`define ACC_SAMPLE_CYC ((`ACC_SAMPLE_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_STEP_CYC ((`ACC_STEP_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)

`endif

// [include/acc_pkg.sv]
// types shared by the converter control block
`default_nettype none

package acc_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acc_state_e;

    // one avalon-mm request as the master presents it
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
    } acc_avs_req_s;

    typedef logic [9:0] acc_result_t;

endpackage : acc_pkg

`default_nettype wire

// [src/acc_top.sv]
// control logic of an eight-channel 10-bit successive-approximation converter
`include "acc_params.svh"
`default_nettype none

module acc_top
    import acc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire acc_avs_req_s avs_req_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    output logic conversion_end_irq_out,
    input wire logic standby_in,
    input wire logic [7:0] shared_port_lines_in,
    output logic [7:0] port_input_en_out,
    input wire logic cmp_in,
    output logic [2:0] channel_out,
    output logic sample_out,
    output logic [9:0] dac_out,
    output logic converter_power_out
);

    localparam logic [3:0] SAMPLE_LAST = 4'(`ACC_SAMPLE_CYC - 1);
    localparam logic [3:0] STEP_LAST = 4'(`ACC_STEP_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic standby_s;
    logic cmp_s;
    logic [7:0] port_s;
    // pins arrive from outside the clock domain
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end
        else
        begin
            sync1_q <= {standby_in, cmp_in, shared_port_lines_in};
            sync2_q <= sync1_q;
        end
    end

    assign standby_s = sync2_q[9];
    assign cmp_s = sync2_q[8];
    assign port_s = sync2_q[7:0];

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle on every access
    logic wait_q;
    logic req;
    logic acc_edge;
    logic wr_fire;
    logic [31:0] rdata_q;
    assign req = avs_req_in.read | avs_req_in.write;
    assign acc_edge = req & ~wait_q;
    assign wr_fire = avs_req_in.write & ~wait_q;
    // waitrequest idles high, drops for the single access edge
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= ~(req & wait_q);
        end
    end

    logic wr_mode;
    logic wr_chan;
    logic wr_status;
    logic wr_mask;
    assign wr_mode = wr_fire && avs_req_in.address == `ACC_OFS_MODE;
    assign wr_chan = wr_fire && avs_req_in.address == `ACC_OFS_CHAN;
    assign wr_status = wr_fire && avs_req_in.address == `ACC_OFS_STATUS;
    assign wr_mask = wr_fire && avs_req_in.address == `ACC_OFS_MASK;

    ////////////////////////////////////////////////////////////////////////
    // software registers
    logic run_q;
    logic [2:0] chan_q;
    logic mask_q;
    // run bit, channel select and mask; channel never clears the flag
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            run_q <= `ACC_RST_RUN;
            chan_q <= `ACC_RST_CHAN;
            mask_q <= `ACC_RST_MASK;
        end
        else
        begin
            if (wr_mode)
            begin
                run_q <= avs_req_in.writedata[`ACC_MODE_RUN_BIT];
            end
            if (wr_chan)
            begin
                chan_q <= avs_req_in.writedata[2:0];
            end
            if (wr_mask)
            begin
                mask_q <= avs_req_in.writedata[`ACC_MASK_DONE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // successive-approximation sequencer
    acc_state_e state_q;
    logic [3:0] cnt_q;
    logic [3:0] bit_q;
    logic [9:0] sar_q;
    logic sample_q;
    logic enable;
    logic restart;
    logic step_end;
    logic done_evt;
    logic [9:0] bit_mask;
    logic [9:0] sar_kept;
    logic [9:0] next_trial;
    // standby or a cleared run bit stops the sequencer; converter power follows the run bit alone
    assign enable = run_q & ~standby_s;
    // a mode or channel write restarts the conversion
    assign restart = wr_mode | wr_chan;
    assign step_end = state_q == ST_CONVERT && cnt_q == STEP_LAST;
    assign bit_mask = 10'h001 << bit_q;
    // comparator low means the trial bit overshoots
    assign sar_kept = cmp_s ? sar_q : (sar_q & ~bit_mask);
    assign next_trial = sar_kept | (bit_mask >> 1);
    // completion lost when a mode or channel write hits it
    assign done_evt = step_end && bit_q == 4'h0 && enable && !restart;

    // sample for the first sixth, then hold for ten bit steps
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
            sample_q <= 1'b0;
        end
        else if (!enable)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sample_q <= 1'b0;
        end
        else if (restart || state_q == ST_IDLE)
        begin
            state_q <= ST_SAMPLE;
            cnt_q <= 4'h0;
            sar_q <= 10'h000;
            sample_q <= 1'b1;
        end
        else
        begin
            unique case (state_q)
                ST_SAMPLE:
                begin
                    if (cnt_q == SAMPLE_LAST)
                    begin
                        state_q <= ST_CONVERT;
                        cnt_q <= 4'h0;
                        bit_q <= 4'h9;
                        sar_q <= 10'h200;
                        sample_q <= 1'b0;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_CONVERT:
                begin
                    if (step_end && bit_q == 4'h0)
                    begin
                        // converts continuously while enabled
                        state_q <= ST_SAMPLE;
                        cnt_q <= 4'h0;
                        sar_q <= sar_kept;
                        sample_q <= 1'b1;
                    end
                    else if (step_end)
                    begin
                        cnt_q <= 4'h0;
                        bit_q <= bit_q - 4'h1;
                        sar_q <= next_trial;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_IDLE:
                begin
                    state_q <= ST_SAMPLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // posting the result against bus traffic
    logic pend_q;
    logic [9:0] pend_data_q;
    logic have;
    logic commit;
    logic [9:0] commit_data;
    assign have = done_evt | pend_q;
    // a read in flight defers the store until it is released
    assign commit = have && !avs_req_in.read && !restart;
    assign commit_data = done_evt ? sar_kept : pend_data_q;

    // deferred completion; a mode or channel write drops it
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pend_q <= 1'b0;
            pend_data_q <= 10'h000;
        end
        else
        begin
            pend_q <= have && avs_req_in.read && !restart;
            if (done_evt)
            begin
                pend_data_q <= sar_kept;
            end
        end
    end

    acc_result_t result_q;
    logic done_q;
    logic done_d;
    logic end_pulse_q;
    logic irq_q;
    // 10-bit result, posted for the channel that was converted
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            result_q <= `ACC_RST_RESULT;
        end
        else if (commit)
        begin
            result_q <= commit_data;
        end
    end

    // done flag: set beats the write-one clear
    always_comb
    begin
        done_d = done_q;
        if (wr_status && avs_req_in.writedata[`ACC_STATUS_DONE_BIT])
        begin
            done_d = 1'b0;
        end
        if (commit)
        begin
            done_d = 1'b1;
        end
    end

    // flag, pulse and level interrupt move on the edge that ends the commit cycle
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            done_q <= 1'b0;
            end_pulse_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            done_q <= done_d;
            end_pulse_q <= commit;
            irq_q <= done_d & mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin sharing and analog front-end controls
    logic [7:0] port_en_q;
    logic power_q;
    // the converted line loses its digital input buffer
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            port_en_q <= 8'hFF;
            power_q <= 1'b0;
        end
        else
        begin
            port_en_q <= enable ? ~(8'h01 << chan_q) : 8'hFF;
            power_q <= run_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the wait cycle
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (avs_req_in.read && wait_q)
        begin
            unique case (avs_req_in.address)
                `ACC_OFS_MODE: rdata_q <= {24'h0, run_q, 7'h00};
                `ACC_OFS_CHAN: rdata_q <= {29'h0, chan_q};
                `ACC_OFS_RESULT: rdata_q <= {22'h0, result_q};
                `ACC_OFS_STATUS: rdata_q <= {31'h0, done_q};
                `ACC_OFS_MASK: rdata_q <= {31'h0, mask_q};
                // the converted line reads as zero while a conversion runs
                `ACC_OFS_PORT: rdata_q <= {24'h0, port_s & port_en_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign irq_out = irq_q;
    assign conversion_end_irq_out = end_pulse_q;
    assign port_input_en_out = port_en_q;
    assign channel_out = chan_q;
    assign sample_out = sample_q;
    assign dac_out = sar_q;
    assign converter_power_out = power_q;

endmodule : acc_top

`default_nettype wire

// [verification/acc_props.sv]
// assertions on the converter control ports
`include "acc_params.svh"
`default_nettype none
module acc_props
    import acc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire acc_avs_req_s avs_req_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic conversion_end_irq_out,
    input wire logic standby_in,
    input wire logic [7:0] port_input_en_out,
    input wire logic [2:0] channel_out,
    input wire logic sample_out,
    input wire logic [9:0] dac_out,
    input wire logic converter_power_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////
    // access edge of a mode or channel write
    logic wr_cfg;
    assign wr_cfg = avs_req_in.write && !avs_waitrequest_out &&
        (avs_req_in.address == `ACC_OFS_MODE ||
        avs_req_in.address == `ACC_OFS_CHAN);
    a_pulse_single: assert property (
        conversion_end_irq_out |=> !conversion_end_irq_out)
        else $error("end pulse too long");
    a_read_first: assert property (
        conversion_end_irq_out |-> !$past(avs_req_in.read))
        else $error("post during read");
    a_write_wins: assert property (
        wr_cfg |=> !conversion_end_irq_out)
        else $error("post despite write");
    a_sample_len: assert property (
        $fell(sample_out) && converter_power_out && !standby_in
        |-> $past(sample_out, 12) && !$past(sample_out, 13))
        else $error("sampling window length");
    a_hold_start: assert property (
        $fell(sample_out) && converter_power_out && !standby_in
        |-> dac_out == 10'h200)
        else $error("first trial code");
    a_standby_halt: assert property (
        standby_in [*5] |-> !sample_out && !conversion_end_irq_out)
        else $error("activity in standby");
    a_power_run: assert property (
        wr_cfg && avs_req_in.address == `ACC_OFS_MODE |-> ##3
        converter_power_out == $past(avs_req_in.writedata[7], 3))
        else $error("power not following run");
    a_port_share: assert property (
        port_input_en_out != 8'hFF && $stable(channel_out)
        |-> port_input_en_out == ~(8'h01 << channel_out))
        else $error("wrong shared line");
    a_result_bits: assert property (
        avs_req_in.read && !avs_waitrequest_out &&
        avs_req_in.address == `ACC_OFS_RESULT
        |-> avs_readdata_out[31:10] == 22'h0)
        else $error("result wider than ten bits");
endmodule : acc_props
bind acc_top acc_props props_u (.*);
`default_nettype wire

// [verification/acc_src_model.sv]
// analog sources: eight levels seen through a sample-and-hold
`default_nettype none
module acc_src_model
(
    input wire logic clk_in,
    input wire logic [79:0] levels_in,
    input wire logic [2:0] channel_in,
    input wire logic sample_in,
    input wire logic [9:0] dac_in,
    output logic cmp_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held_q;
    // charge only while sampling, so a late window converts stale levels
    always_ff @(posedge clk_in)
    begin
        if (sample_in)
            held_q <= levels_in[channel_in * 10 +: 10];
    end
    assign cmp_out = held_q >= dac_in;
endmodule : acc_src_model
`default_nettype wire

// [verification/tb_acc_top.sv]
// self-checking bench of the converter control
`include "acc_params.svh"
`default_nettype none
module tb_acc_top
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0;
    logic rst_in = 1;
    logic standby_in = 0;
    logic cmp_in;
    acc_avs_req_s avs_req_in = '0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic irq_out;
    logic conversion_end_irq_out;
    logic [7:0] shared_port_lines_in = 8'hA5;
    logic [7:0] port_input_en_out;
    logic [2:0] channel_out;
    logic sample_out;
    logic [9:0] dac_out;
    logic converter_power_out;
    logic [79:0] levels = {20'h0, 10'h15A, 10'h0, 10'h2A5, 30'h0};
    logic [4:0] ofs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18};
    logic [31:0] rd;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 clk_in = ~clk_in;
    acc_top dut_u (.*);
    acc_src_model src_u (.clk_in(clk_in), .levels_in(levels),
        .channel_in(channel_out), .sample_in(sample_out),
        .dac_in(dac_out), .cmp_out(cmp_in));
    ////////////////////////////////
    task automatic close_out();
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input string w, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask : chk
    // requests held until waitrequest is seen low
    task automatic bw(input logic [4:0] a, input logic [31:0] d);
        avs_req_in <= '{1'b0, 1'b1, a, d};
        do @(posedge clk_in); while (avs_waitrequest_out);
        avs_req_in <= '0;
        @(posedge clk_in);
    endtask : bw
    task automatic rc(input logic [4:0] a, input logic [31:0] e,
        input string w);
        avs_req_in <= '{1'b1, 1'b0, a, 32'h0};
        do @(posedge clk_in); while (avs_waitrequest_out);
        rd = avs_readdata_out;
        avs_req_in <= '0;
        @(posedge clk_in);
        chk(w, e, rd);
    endtask : rc
    task automatic wp();
        int k;
        k = 0;
        do
        begin
            @(posedge clk_in);
            k++;
        end
        while (conversion_end_irq_out !== 1'b1 && k < 200);
        chk("end pulse", 1, conversion_end_irq_out);
    endtask : wp
    // hang guard, far above the fewer than a thousand cycles needed
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            close_out();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        foreach (ofs[i])
            rc(ofs[i], 0, "reset value");
        bw(`ACC_OFS_MASK, 1);
        bw(`ACC_OFS_CHAN, 3);
        chk("channel pins", 3, channel_out);
        bw(`ACC_OFS_MODE, 32'h80);
        wp();
        chk("irq", 1, irq_out);
        chk("port enables", 8'hF7, port_input_en_out);
        rc(`ACC_OFS_RESULT, 10'h2A5, "result ch3");
        rc(`ACC_OFS_STATUS, 1, "done flag");
        // leave the sampling window before rewriting the channel
        repeat (20) @(posedge clk_in);
        bw(`ACC_OFS_CHAN, 5);
        rc(`ACC_OFS_STATUS, 1, "flag after channel");
        // a masked flag keeps the level interrupt low
        bw(`ACC_OFS_MASK, 0);
        @(posedge clk_in);
        chk("irq masked", 0, irq_out);
        bw(`ACC_OFS_MASK, 1);
        bw(`ACC_OFS_STATUS, 1);
        rc(`ACC_OFS_STATUS, 0, "flag cleared");
        chk("irq cleared", 0, irq_out);
        wp();
        rc(`ACC_OFS_RESULT, 10'h15A, "result ch5");
        // channel write lands on the completion edge, 72 after the last
        wp();
        bw(`ACC_OFS_STATUS, 1);
        repeat (66) @(posedge clk_in);
        bw(`ACC_OFS_CHAN, 5);
        repeat (60)
        begin
            chk("dropped pulse", 0, conversion_end_irq_out);
            @(posedge clk_in);
        end
        rc(`ACC_OFS_STATUS, 0, "dropped flag");
        rc(`ACC_OFS_RESULT, 10'h15A, "dropped result");
        // reads back to back keep the new result waiting
        levels[59:50] <= 10'h3C0;
        wp();
        avs_req_in <= '{1'b1, 1'b0, `ACC_OFS_RESULT, 32'h0};
        repeat (100)
        begin
            @(posedge clk_in);
            chk("pulse in read", 0, conversion_end_irq_out);
        end
        while (avs_waitrequest_out) @(posedge clk_in);
        chk("held result", 10'h15A, avs_readdata_out);
        avs_req_in <= '0;
        wp();
        rc(`ACC_OFS_RESULT, 10'h3C0, "result after read");
        standby_in <= 1;
        repeat (100)
        begin
            @(posedge clk_in);
            chk("pulse in standby", 0, conversion_end_irq_out);
        end
        chk("sample in standby", 0, sample_out);
        standby_in <= 0;
        wp();
        repeat (20) @(posedge clk_in);
        bw(`ACC_OFS_MODE, 0);
        @(posedge clk_in);
        chk("power off", 0, converter_power_out);
        chk("port enables idle", 8'hFF, port_input_en_out);
        rc(`ACC_OFS_PORT, 8'hA5, "port lines");
        bw(`ACC_OFS_STATUS, 1);
        bw(`ACC_OFS_MODE, 32'h80);
        wp();
        close_out();
    end
endmodule : tb_acc_top
`default_nettype wire
